// ### hw/sleep_mode_power_control.sv
// sleep mode power controller: clock gating, regulator standby and wake logic
//
// Contract
// - sleep entry stops system clock and turns off on-chip oscillator used as source.
// - clock fail supervisor held inactive while asleep.
// - low power rc oscillator stays running during sleep if watchdog enabled.
// - watchdog count cleared before sleep entry completes, when watchdog enabled.
// - pin change detect and externally clocked peripherals keep running in sleep.
// - peripherals needing system clock held disabled during sleep.
// - wake on enabled interrupt, any reset, or watchdog time-out.
// - after wake, cpu resumes on clock source selected at sleep entry.
// - keep-active bits clear (default) puts both regulators in standby in sleep.
// - keep-active bits set keep both regulators active during sleep.
// - interrupt during power save instruction held off until entry completes.
//
// sequence: run, two entry cycles (watchdog cleared in the first), sleep, one wake
// cycle, then run again. a reset request seen mid-entry aborts straight to wake; an
// interrupt there is only latched, so the device still reaches sleep before waking.
// wake inputs from other domains must stand for two cycles or they may be missed.
`timescale 1ns/100ps
module sleep_mode_power_control
  import sleep_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_power_save_instruction,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_timeout,
  input wire logic i_irq_pending,
  input wire logic i_dev_reset_req,
  input wire logic [RESET_CTRL_WIDTH-1:0] i_reset_control_reg,
  input wire logic [CLK_SEL_WIDTH-1:0] i_clk_sel,
  input wire logic i_clk_sel_is_onchip,
  input wire logic i_pin_change_detect,
  output logic o_sleeping,
  output logic o_sys_clk_en,
  output logic o_onchip_osc_en,
  output logic o_clock_fail_supervisor_en,
  output logic o_low_power_rc_oscillator_en,
  output logic o_wdt_clear,
  output logic o_periph_sysclk_en,
  output logic o_async_periph_en,
  output logic o_pin_change_wake,
  output logic o_main_reg_standby,
  output logic o_flash_reg_standby,
  output logic [CLK_SEL_WIDTH-1:0] o_resume_clk_sel,
  output logic o_cpu_resume
);

  power_state_t state_r;
  power_state_t state_nxt;
  logic [1:0] entry_cnt_r;
  logic [1:0] wake_in_s;
  logic wdt_timeout_s;
  logic dev_reset_s;
  logic wake_event;
  logic irq_held_r;
  logic [CLK_SEL_WIDTH-1:0] saved_sel_r;
  logic saved_onchip_r;
  logic main_keep;
  logic flash_keep;

  // decoded in one place; the gates, the standby bits and the rc enable all key off it
  function automatic logic is_sleep(input power_state_t st);
    return st == ST_SLEEP;
  endfunction : is_sleep

  // a request counts only from run; elsewhere the cpu is already parked or waking
  function automatic logic takes_request(input power_state_t st, input logic req);
    return (st == ST_RUN) && req;
  endfunction : takes_request

  // a regulator idles only while asleep and only when its keep bit is clear
  function automatic logic standby_for(input logic asleep, input logic keep);
    return asleep & ~keep;
  endfunction : standby_for

  // watchdog timer and external reset request arrive from other domains
  wake_sync #(
    .WIDTH(2)
  ) u_wake_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_wdt_timeout, i_dev_reset_req}),
    .o_sync(wake_in_s)
  );

  assign wdt_timeout_s = wake_in_s[1];
  assign dev_reset_s = wake_in_s[0];

  // the held flag counts too, so an interrupt that arrived during entry is not lost
  // any of the three wakes
  assign wake_event = i_irq_pending | irq_held_r | dev_reset_s | wdt_timeout_s;

  // regulator keep-active controls from the reset control register
  assign main_keep = i_reset_control_reg[MAIN_REG_KEEP_BIT];
  assign flash_keep = i_reset_control_reg[FLASH_REG_KEEP_BIT];

  // next state of the power sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (i_power_save_instruction) begin
          state_nxt = ST_ENTER;
        end
      end
      ST_ENTER: begin
        // a reset still aborts entry; interrupts wait for completion
        if (dev_reset_s) begin
          state_nxt = ST_WAKE;
        end else if (entry_cnt_r == ENTRY_CNT_LAST) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_event) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // entry cycle counter, restarts each time entry begins
  // it counts only inside entry, so an aborted entry leaves no stale count behind
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      entry_cnt_r <= 2'h0;
    end else if (state_r == ST_ENTER) begin
      entry_cnt_r <= entry_cnt_r + 2'h1;
    end else begin
      entry_cnt_r <= 2'h0;
    end
  end

  // set and clear never meet: set only in entry, cleared only in wake
  // latch interrupt seen during entry
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_held_r <= 1'b0;
    end else if (state_r == ST_ENTER && i_irq_pending) begin
      irq_held_r <= 1'b1;
    end else if (state_r == ST_WAKE) begin
      irq_held_r <= 1'b0;
    end
  end

  // captured on the taking edge, so later moves of the live select are ignored
  // remember clock source at sleep request
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      saved_sel_r <= CLK_SEL_RESET;
      saved_onchip_r <= 1'b0;
    end else if (takes_request(state_r, i_power_save_instruction)) begin
      saved_sel_r <= i_clk_sel;
      saved_onchip_r <= i_clk_sel_is_onchip;
    end
  end

  // every gate below is registered from the next state, so all of them move on the
  // edge at which the state lands and none can glitch on a decode
  // sleep flag follows state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sleeping <= 1'b0;
    end else begin
      o_sleeping <= is_sleep(state_nxt);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sys_clk_en <= 1'b1;
    end else begin
      o_sys_clk_en <= ~is_sleep(state_nxt);
    end
  end

  // an external source is not ours to stop, so only an on-chip one is gated
  // on-chip source off
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_onchip_osc_en <= 1'b1;
    end else begin
      o_onchip_osc_en <= ~is_sleep(state_nxt) | ~saved_onchip_r;
    end
  end

  // left running it would report the stopped clock as a failure
  // supervisor off asleep
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_clock_fail_supervisor_en <= 1'b1;
    end else begin
      o_clock_fail_supervisor_en <= ~is_sleep(state_nxt);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_periph_sysclk_en <= 1'b1;
    end else begin
      o_periph_sysclk_en <= ~is_sleep(state_nxt);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_low_power_rc_oscillator_en <= 1'b0;
    end else begin
      o_low_power_rc_oscillator_en <= ~is_sleep(state_nxt) | i_wdt_enable;
    end
  end

  // clear watchdog in first entry cycle, before sleep is reached
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wdt_clear <= 1'b0;
    end else begin
      o_wdt_clear <= i_wdt_enable && takes_request(state_r, i_power_save_instruction);
    end
  end

  // the enable comes up on the first edge out of reset and never drops for sleep
  // asynchronous peripherals stay on
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_async_periph_en <= 1'b0;
    end else begin
      o_async_periph_en <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin_change_wake <= 1'b0;
    end else begin
      o_pin_change_wake <= i_pin_change_detect;
    end
  end

  // each regulator follows its own keep bit; the two bits need not agree
  // main regulator standby
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_main_reg_standby <= 1'b0;
    end else begin
      o_main_reg_standby <= standby_for(is_sleep(state_nxt), main_keep);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flash_reg_standby <= 1'b0;
    end else begin
      o_flash_reg_standby <= standby_for(is_sleep(state_nxt), flash_keep);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_resume_clk_sel <= CLK_SEL_RESET;
    end else begin
      o_resume_clk_sel <= saved_sel_r;
    end
  end

  // one cycle only; the cpu restarts on this pulse with the source above
  // resume pulse after wake
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cpu_resume <= 1'b0;
    end else begin
      o_cpu_resume <= (state_r == ST_WAKE);
    end
  end

endmodule : sleep_mode_power_control

// ### hw/sleep_ctrl_pkg.sv
// shared constants and state encoding for the sleep mode power controller
package sleep_ctrl_pkg;

  // bit positions of the regulator standby controls in the reset control register
  localparam int unsigned MAIN_REG_KEEP_BIT = 8;
  localparam int unsigned FLASH_REG_KEEP_BIT = 11;
  localparam int unsigned RESET_CTRL_WIDTH = 16;

  // width of the clock source select code
  localparam int unsigned CLK_SEL_WIDTH = 3;
  localparam logic [2:0] CLK_SEL_RESET = 3'h0;

  // cycles the entry sequence spends clearing the watchdog and gating clocks
  localparam int unsigned ENTRY_CYCLES = 2;
  localparam logic [1:0] ENTRY_CNT_LAST = 2'(ENTRY_CYCLES - 1);

  // power state machine
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ENTER = 2'b01,
    ST_SLEEP = 2'b10,
    ST_WAKE = 2'b11
  } power_state_t;

endpackage : sleep_ctrl_pkg

// ### hw/wake_sync.sv
// two-flop synchroniser for wake inputs coming from outside the clock domain
`timescale 1ns/100ps
module wake_sync
  import sleep_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : wake_sync

// ### sim/sleep_ctrl_assertions.sv
// port-level checker for the sleep mode power controller
`timescale 1ns/100ps
module sleep_ctrl_chk
  import sleep_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_power_save_instruction,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_timeout,
  input wire logic i_irq_pending,
  input wire logic i_dev_reset_req,
  input wire logic [RESET_CTRL_WIDTH-1:0] i_reset_control_reg,
  input wire logic i_clk_sel_is_onchip,
  input wire logic i_pin_change_detect,
  input wire logic o_sleeping,
  input wire logic o_sys_clk_en,
  input wire logic o_onchip_osc_en,
  input wire logic o_clock_fail_supervisor_en,
  input wire logic o_low_power_rc_oscillator_en,
  input wire logic o_wdt_clear,
  input wire logic o_periph_sysclk_en,
  input wire logic o_async_periph_en,
  input wire logic o_pin_change_wake,
  input wire logic o_main_reg_standby,
  input wire logic o_flash_reg_standby,
  input wire logic o_cpu_resume
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic any_wake;
  // any cause that may end sleep; synced causes arrive a few cycles late
  assign any_wake = i_irq_pending | i_wdt_timeout | i_dev_reset_req;
  clk_gate_a: assert property (o_sleeping |-> !o_sys_clk_en && !o_periph_sysclk_en)
    else $error("clock left on in sleep");
  osc_off_a: assert property (o_sleeping && i_clk_sel_is_onchip |-> !o_onchip_osc_en)
    else $error("on-chip oscillator left on");
  supervisor_off_a: assert property (o_sleeping |-> !o_clock_fail_supervisor_en)
    else $error("supervisor active in sleep");
  rc_keep_a: assert property (o_sleeping && i_wdt_enable |-> o_low_power_rc_oscillator_en)
    else $error("rc oscillator stopped");
  wdt_clear_a: assert property ($rose(o_sleeping) && i_wdt_enable |-> $past(o_wdt_clear, 2))
    else $error("watchdog not cleared on entry");
  entry_req_a: assert property ($rose(o_sleeping) |-> $past(i_power_save_instruction, 3))
    else $error("sleep without request");
  standby_a: assert property (o_sleeping |-> o_main_reg_standby == !i_reset_control_reg[8]
    && o_flash_reg_standby == !i_reset_control_reg[11]) else $error("regulator standby wrong");
  pin_live_a: assert property (o_sleeping |-> o_async_periph_en
    && o_pin_change_wake == $past(i_pin_change_detect)) else $error("pin change path stopped");
  irq_wake_a: assert property (o_sleeping && i_irq_pending |=> !o_sleeping ##1 o_cpu_resume)
    else $error("no wake on interrupt");
  wake_cause_a: assert property ($fell(o_sleeping) |-> $past(any_wake) || $past(any_wake, 2)
    || $past(any_wake, 3) || $past(any_wake, 4)) else $error("woke without cause");
endmodule : sleep_ctrl_chk
bind sleep_mode_power_control sleep_ctrl_chk chk_u (.*);

// ### sim/tb_sleep_mode_power_control.sv
// self-checking bench for the sleep mode power controller
`timescale 1ns/100ps
module tb_sleep_mode_power_control;
  import sleep_ctrl_pkg::*;
  logic i_clk, i_rst_b, i_power_save_instruction, i_wdt_enable, i_wdt_timeout, i_irq_pending;
  logic i_dev_reset_req, i_clk_sel_is_onchip, i_pin_change_detect;
  logic [15:0] i_reset_control_reg;
  logic [2:0] i_clk_sel, o_resume_clk_sel;
  logic o_sleeping, o_sys_clk_en, o_onchip_osc_en, o_clock_fail_supervisor_en, o_wdt_clear;
  logic o_low_power_rc_oscillator_en, o_periph_sysclk_en, o_async_periph_en, o_pin_change_wake;
  logic o_main_reg_standby, o_flash_reg_standby, o_cpu_resume;
  int errors, tests_run, n;
  sleep_mode_power_control dut_u (.*);
  // free-running 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task tally_and_finish;
    $display("tests %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // inputs move only on the falling edge, away from the sampling edge
  task tick(input int c);
    repeat (c) @(negedge i_clk);
  endtask : tick
  // one-cycle sleep request; returns just after the taking edge
  task ask;
    i_power_save_instruction = 1'b1;
    tick(1);
    i_power_save_instruction = 1'b0;
  endtask : ask
  // bounded wait for the resume pulse
  task wait_resume;
    n = 0;
    while (o_cpu_resume !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
  endtask : wait_resume
  task t_sleep(input logic w, input logic oc, input logic [15:0] r, input logic [2:0] s);
    i_wdt_enable = w;
    i_clk_sel_is_onchip = oc;
    i_reset_control_reg = r;
    i_clk_sel = s;
    tick(1);
    ask();
    check(o_wdt_clear, w);
    tick(2);
    check(o_sleeping, 1);
    check({o_sys_clk_en, o_periph_sysclk_en}, 0);
    check(o_onchip_osc_en, !oc);
    check(o_clock_fail_supervisor_en, 0);
    check(o_low_power_rc_oscillator_en, w);
    check({o_flash_reg_standby, o_main_reg_standby}, {!r[11], !r[8]});
    // move the live select so a resume on the wrong source shows
    i_clk_sel = ~s;
    i_pin_change_detect = 1'b1;
    tick(1);
    check({o_async_periph_en, o_pin_change_wake}, 3);
    i_pin_change_detect = 1'b0;
    i_irq_pending = 1'b1;
    tick(1);
    check(o_sleeping, 0);
    i_irq_pending = 1'b0;
    tick(1);
    check(o_cpu_resume, 1);
    check(o_resume_clk_sel, s);
    $display("sleep pass done");
  endtask : t_sleep
  task t_wake(input logic by_reset);
    i_wdt_enable = 1'b1;
    ask();
    tick(12);
    check(o_sleeping, 1);
    i_dev_reset_req = by_reset;
    i_wdt_timeout = !by_reset;
    tick(2);
    i_dev_reset_req = 1'b0;
    i_wdt_timeout = 1'b0;
    wait_resume();
    check(o_cpu_resume, 1);
    $display("slow wake done");
  endtask : t_wake
  task t_hold;
    ask();
    i_irq_pending = 1'b1;
    tick(1);
    i_irq_pending = 1'b0;
    check(o_sleeping, 0);
    tick(1);
    check(o_sleeping, 1);
    wait_resume();
    check(o_cpu_resume, 1);
    $display("held interrupt done");
  endtask : t_hold
  initial begin
    {i_rst_b, i_power_save_instruction, i_wdt_enable, i_wdt_timeout, i_irq_pending} = '0;
    {i_dev_reset_req, i_clk_sel_is_onchip, i_pin_change_detect} = '0;
    i_reset_control_reg = 16'h0000;
    i_clk_sel = 3'h0;
    // count rising edges so the x-to-0 start of the clock is not taken for an edge
    repeat (3) @(posedge i_clk);
    tick(1);
    i_rst_b = 1'b1;
    tick(1);
    check({o_sleeping, o_sys_clk_en}, 1);
    t_sleep(1'b1, 1'b1, 16'h0000, 3'h5);
    t_sleep(1'b0, 1'b0, 16'h0900, 3'h2);
    t_sleep(1'b1, 1'b0, 16'h0100, 3'h7);
    t_wake(1'b0);
    t_wake(1'b1);
    t_hold();
    tally_and_finish();
  end
  // the run needs about 65 cycles; cut a hang short well beyond that
  initial begin
    #20us;
    errors++;
    tally_and_finish();
  end
endmodule : tb_sleep_mode_power_control
